// file: core/ofpc_pkg.sv
package ofpc_pkg;

////////////////////////////////////////////////////////////////////////
localparam int unsigned CLK_KHZ   = 40000;
localparam int unsigned RETRY_MS  = 70;
localparam int unsigned RETRY_CYC = RETRY_MS * CLK_KHZ;
localparam int unsigned OV_PCT    = 15;
localparam int unsigned RIPPLE_K  = 4000;  // 1e6 / inductance in nH
localparam int unsigned STEP_LOG  = 8;     // Ramp is 2**STEP_LOG steps

localparam logic [6:0]  ADDR_MIN  = 7'h19;
localparam logic [6:0]  ADDR_MAX  = 7'h37;
localparam logic [6:0]  ADDR_DEF  = 7'h28;
localparam logic [3:0]  HALF_TURN = 4'h8;

// Reset values
localparam logic [15:0] SETPT_RST = 16'h03E8;
localparam logic [15:0] OCLIM_RST = 16'hC350;
localparam logic [15:0] OTLIM_RST = 16'h0073;
localparam logic [31:0] DLY_RST   = 32'h00009C40;
localparam logic [15:0] RSTEP_RST = 16'h009C;
localparam logic [15:0] FSW_RST   = 16'h01A5;

// Register byte offsets
localparam logic [7:0] OFF_CTRL  = 8'h00;
localparam logic [7:0] OFF_STAT  = 8'h04;
localparam logic [7:0] OFF_SETPT = 8'h08;
localparam logic [7:0] OFF_OVLIM = 8'h0C;
localparam logic [7:0] OFF_OCLIM = 8'h10;
localparam logic [7:0] OFF_OTLIM = 8'h14;
localparam logic [7:0] OFF_ILV   = 8'h18;
localparam logic [7:0] OFF_DLY   = 8'h1C;
localparam logic [7:0] OFF_RSTEP = 8'h20;
localparam logic [7:0] OFF_FSW   = 8'h24;
localparam logic [7:0] OFF_VIN   = 8'h30;
localparam logic [7:0] OFF_VOUT  = 8'h34;
localparam logic [7:0] OFF_IOUT  = 8'h38;
localparam logic [7:0] OFF_TEMP  = 8'h3C;
localparam logic [7:0] OFF_DUTY  = 8'h40;
localparam logic [7:0] OFF_FREQ  = 8'h44;
localparam logic [7:0] OFF_VMON  = 8'h48;
localparam logic [7:0] OFF_SFLT  = 8'h50;
localparam logic [7:0] OFF_SVIN  = 8'h54;
localparam logic [7:0] OFF_SVOUT = 8'h58;
localparam logic [7:0] OFF_SIOUT = 8'h5C;
localparam logic [7:0] OFF_STEMP = 8'h60;

// Field positions
localparam int CTRL_EN  = 0;
localparam int CTRL_CLR = 1;
localparam int ILV_OVR  = 4;
localparam int ST_PG    = 3;
localparam int ST_DRV   = 4;
localparam int ST_FLT   = 5;
localparam int ST_ADDR  = 10;

typedef enum logic [2:0] {
    OFPC_OFF    = 3'h0,
    OFPC_DELAY  = 3'h1,
    OFPC_RAMP   = 3'h3,
    OFPC_ON     = 3'h2,
    OFPC_HOLD   = 3'h6,
    OFPC_SETTLE = 3'h7,
    OFPC_RETRY  = 3'h5,
    OFPC_LATCH  = 3'h4
} ofpc_st_t;

// Voltages mV, currents mA, temperature degC two's complement
typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vsp;
    logic [15:0] vsn;
    logic [15:0] iout;
    logic [15:0] ipk;
    logic [15:0] temp;
    logic [15:0] vmon;
} ofpc_adc_t;

typedef struct packed {
    logic ot;
    logic pbov;
    logic ocpk;
    logic ocavg;
    logic ov;
} ofpc_flt_t;

endpackage

// file: core/ofpc_ramp.sv
`timescale 1ns/1ps
module ofpc_ramp
    import ofpc_pkg::*;
#(
    parameter int STEPS_LOG = STEP_LOG
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        abort_i,
    input  wire logic [15:0] from_i,
    input  wire logic [15:0] to_i,
    input  wire logic [15:0] step_cyc_i,
    output logic      [15:0] value_o,
    output logic             busy_o,
    output logic             done_o
);

    typedef struct packed {
        logic                 busy;
        logic                 done;
        logic [STEPS_LOG:0]   idx;
        logic [15:0]          cnt;
        logic [15:0]          from;
        logic [15:0]          to;
        logic signed [16:0]   diff;
        logic [15:0]          val;
    } ofpc_ramp_st_t;

    ofpc_ramp_st_t q;
    ofpc_ramp_st_t d;

    // Fixed step count makes total time independent of the start level
    always_comb begin
        logic [STEPS_LOG:0]  nidx;
        logic signed [27:0]  prod;
        logic signed [27:0]  sum;
        nidx   = q.idx + 1'b1;
        prod   = 28'(q.diff * $signed({1'b0, nidx}));
        sum    = $signed({12'h000, q.from}) + (prod >>> STEPS_LOG);
        d      = q;
        d.done = 1'b0;
        if (abort_i) begin
            d.busy = 1'b0;
        end else if (start_i) begin
            d.busy = 1'b1;
            d.idx  = '0;
            d.cnt  = '0;
            d.from = from_i;
            d.to   = to_i;
            d.diff = $signed({1'b0, to_i}) - $signed({1'b0, from_i});
            d.val  = from_i;
        end else if (q.busy) begin
            if (q.cnt + 16'h0001 >= step_cyc_i) begin
                d.cnt = '0;
                d.idx = nidx;
                d.val = sum[15:0];
                if (nidx[STEPS_LOG]) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.val  = q.to;
                end
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign value_o = q.val;
    assign busy_o  = q.busy;
    assign done_o  = q.done;

endmodule // ofpc_ramp

// file: core/ofpc_top.sv
`timescale 1ns/1ps
module ofpc_top
    import ofpc_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_cyc_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire ofpc_adc_t   adc_i,
    input  wire logic        en_i,
    input  wire logic [6:0]  addr_strap_i,
    output logic             drv_en_o,
    output logic      [15:0] target_o,
    output logic      [15:0] duty_o,
    output logic             power_good_out_o,
    output logic      [3:0]  phase_a_o,
    output logic      [3:0]  phase_b_o,
    output logic             fault_o
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ofpc_adc_t   s1;
        ofpc_adc_t   s2;
        logic        en1;
        logic        en2;
        logic [6:0]  a1;
        logic [6:0]  a2;
        logic [1:0]  sdly;
        logic [6:0]  addr;
        logic        ctl_en;
        logic [15:0] setpt;
        logic [15:0] ovlim;
        logic        ov_user;
        logic [15:0] oclim;
        logic [15:0] otlim;
        logic [3:0]  ilv;
        logic        ilv_user;
        logic [31:0] dly;
        logic [15:0] rstep;
        logic [15:0] fsw;
        ofpc_st_t    st;
        logic [31:0] cnt;
        logic [15:0] pb;
        logic [15:0] tgt;
        logic        drv;
        logic        pg;
        ofpc_flt_t   flt;
        ofpc_flt_t   sflt;
        ofpc_adc_t   snap;
        logic [15:0] vd;
        logic [15:0] ovl;
        logic [15:0] pkl;
        logic [15:0] duty;
        logic        rstart;
        logic [15:0] rfrom;
        logic        ack;
        logic [31:0] rdat;
    } ofpc_top_st_t;

    ofpc_top_st_t q;
    ofpc_top_st_t d;
    logic [15:0]  r_val;
    logic         r_busy;
    logic         r_done;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] ov_default(input logic [15:0] v);
        logic [31:0] inc;
        inc = (32'(v) * OV_PCT) / 32'd100;
        return v + inc[15:0];
    endfunction

    // Ripple = (vin - vout) * vout / (vin * L * fsw); limit adds half
    function automatic logic [15:0] peak_lim(input logic [15:0] vin,
                                             input logic [15:0] vout,
                                             input logic [15:0] fsw,
                                             input logic [15:0] oc);
        logic [63:0] num;
        logic [63:0] den;
        logic [63:0] lim;
        num = 64'(vin - vout) * 64'(vout) * 64'(RIPPLE_K);
        den = 64'(vin) * 64'(fsw);
        lim = 64'(oc);
        if (vin > vout && den != 64'h0) begin
            lim = lim + ((num / den) >> 1);
        end
        return (lim > 64'h0000FFFF) ? 16'hFFFF : lim[15:0];
    endfunction

    function automatic logic [15:0] duty_of(input logic [15:0] v,
                                            input logic [15:0] vin);
        logic [31:0] r;
        r = (vin == 16'h0000) ? 32'h0000FFFF
                              : (32'(v) * 32'h0000FFFF) / 32'(vin);
        return (r > 32'h0000FFFF) ? 16'hFFFF : r[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic      on;
        logic      acc;
        logic      wr;
        logic      clr;
        logic      oc;
        ofpc_flt_t nf;
        logic [31:0] rd;
        on  = q.ctl_en & q.en2;
        acc = wb_cyc_i & wb_stb_i & ~q.ack;
        wr  = acc & wb_we_i;
        clr = wr && wb_adr_i == OFF_CTRL && wb_sel_i[0]
              && wb_dat_i[CTRL_CLR];
        nf  = '0;
        rd  = 32'h00000000;
        oc  = 1'b0;
        d   = q;
        d.rstart = 1'b0;

        // Two-stage synchronisers for pins and converter samples
        d.s1  = adc_i;
        d.s2  = q.s1;
        d.en1 = en_i;
        d.en2 = q.en1;
        d.a1  = addr_strap_i;
        d.a2  = q.a1;

        // Strap is caught once, when the synchroniser has filled
        if (q.sdly != 2'h3) begin
            d.sdly = q.sdly + 2'h1;
        end
        if (q.sdly == 2'h2) begin
            d.addr = (q.a2 >= ADDR_MIN && q.a2 <= ADDR_MAX)
                     ? q.a2 : ADDR_DEF;
        end
        if (!q.ilv_user) begin
            d.ilv = q.addr[3:0];
        end

        d.vd   = (q.s2.vsp > q.s2.vsn) ? q.s2.vsp - q.s2.vsn : 16'h0000;
        d.ovl  = q.ov_user ? q.ovlim : ov_default(q.setpt);
        d.pkl  = peak_lim(q.s2.vin, q.setpt, q.fsw, q.oclim);

        // Fault detection: ov and overcurrent while switching, ot in every state but latch
        nf.ov    = q.drv && q.vd > q.ovl;
        nf.ocavg = q.drv && q.s2.iout > q.oclim;
        nf.ocpk  = q.drv && q.s2.ipk > q.pkl;
        nf.ot    = q.st != OFPC_LATCH
                   && $signed(q.s2.temp) > $signed(q.otlim);

        ////////////////////////////////////////////////////////////////
        case (q.st)
            OFPC_OFF: begin
                d.drv = 1'b0;
                d.pg  = 1'b0;
                if (on) begin
                    d.st  = OFPC_DELAY;
                    d.cnt = '0;
                end
            end
            OFPC_DELAY: begin
                d.cnt = q.cnt + 32'h1;
                d.pb  = q.vd;
                if (q.cnt >= q.dly) begin
                    d.cnt = '0;
                    d.tgt = q.vd;
                    if (q.vd > q.ovl) begin
                        nf.pbov = 1'b1;
                    end else if (q.vd <= q.setpt) begin
                        d.drv    = 1'b1;
                        d.rstart = 1'b1;
                        d.rfrom  = q.vd;
                        d.st     = OFPC_RAMP;
                    end else begin
                        d.drv = 1'b1;
                        d.st  = OFPC_HOLD;
                    end
                end
            end
            OFPC_RAMP: begin
                if (r_busy || r_done) begin
                    d.tgt = r_val;
                end
                if (r_done) begin
                    d.pg = 1'b1;
                    d.st = OFPC_ON;
                end
            end
            OFPC_HOLD: begin
                // Same duration as a full ramp from the delay end
                d.cnt = q.cnt + 32'h1;
                if (q.cnt + 32'h1 >= {8'h00, q.rstep, 8'h00}) begin
                    d.pg     = 1'b1;
                    d.rstart = 1'b1;
                    d.rfrom  = q.pb;
                    d.st     = OFPC_SETTLE;
                end
            end
            OFPC_SETTLE: begin
                if (r_busy || r_done) begin
                    d.tgt = r_val;
                end
                if (r_done) begin
                    d.st = OFPC_ON;
                end
            end
            OFPC_ON: begin
                d.tgt = q.setpt;
            end
            OFPC_RETRY: begin
                d.cnt = q.cnt + 32'h1;
                if (q.cnt >= RETRY_CYCLES - 1) begin
                    d.cnt = '0;
                    d.st  = OFPC_DELAY;
                end
            end
            OFPC_LATCH: begin
                if (clr || !on) begin
                    d.st = OFPC_OFF;
                end
            end
            default: begin
                d.st = OFPC_OFF;
            end
        endcase

        // Shutdown priority: latched faults beat retry, retry beats off
        oc = nf.ocavg | nf.ocpk;
        if (nf.ov || nf.pbov || nf.ot) begin
            d.st  = OFPC_LATCH;
            d.drv = 1'b0;
            d.pg  = 1'b0;
        end else if (oc) begin
            d.st  = OFPC_RETRY;
            d.cnt = '0;
            d.drv = 1'b0;
            d.pg  = 1'b0;
        end else if (!on && q.st != OFPC_LATCH) begin
            d.st  = OFPC_OFF;
            d.drv = 1'b0;
            d.pg  = 1'b0;
        end

        // Duty follows the next drive state, so it never outlives drv
        d.duty = d.drv ? duty_of(d.tgt, q.s2.vin) : 16'h0000;

        // A fault raised in the clearing cycle survives the clear
        d.flt = (clr ? '0 : q.flt) | nf;
        if (nf != '0) begin
            d.snap = q.s2;
            d.sflt = q.flt | nf;
        end

        ////////////////////////////////////////////////////////////////
        if (wr) begin
            case (wb_adr_i)
                OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        d.ctl_en = wb_dat_i[CTRL_EN];
                    end
                end
                OFF_SETPT: d.setpt = 16'(wmask(32'(q.setpt), wb_dat_i,
                                               wb_sel_i));
                OFF_OVLIM: begin
                    d.ovlim   = 16'(wmask(32'(q.ovlim), wb_dat_i,
                                          wb_sel_i));
                    d.ov_user = 1'b1;
                end
                OFF_OCLIM: d.oclim = 16'(wmask(32'(q.oclim), wb_dat_i,
                                               wb_sel_i));
                OFF_OTLIM: d.otlim = 16'(wmask(32'(q.otlim), wb_dat_i,
                                               wb_sel_i));
                OFF_ILV: begin
                    if (wb_sel_i[0]) begin
                        d.ilv_user = wb_dat_i[ILV_OVR];
                        d.ilv      = wb_dat_i[ILV_OVR] ? wb_dat_i[3:0]
                                                       : q.addr[3:0];
                    end
                end
                OFF_DLY:   d.dly = wmask(q.dly, wb_dat_i, wb_sel_i);
                OFF_RSTEP: d.rstep = 16'(wmask(32'(q.rstep), wb_dat_i,
                                               wb_sel_i));
                OFF_FSW:   d.fsw = 16'(wmask(32'(q.fsw), wb_dat_i,
                                             wb_sel_i));
                default: ;
            endcase
        end

        case (wb_adr_i)
            OFF_CTRL:  rd = {31'h0, q.ctl_en};
            OFF_STAT:  rd = {15'h0, q.addr, q.flt, q.drv, q.pg, q.st};
            OFF_SETPT: rd = {16'h0, q.setpt};
            OFF_OVLIM: rd = {16'h0, q.ovl};
            OFF_OCLIM: rd = {16'h0, q.oclim};
            OFF_OTLIM: rd = {16'h0, q.otlim};
            OFF_ILV:   rd = {27'h0, q.ilv_user, q.ilv};
            OFF_DLY:   rd = q.dly;
            OFF_RSTEP: rd = {16'h0, q.rstep};
            OFF_FSW:   rd = {16'h0, q.fsw};
            OFF_VIN:   rd = {16'h0, q.s2.vin};
            OFF_VOUT:  rd = {16'h0, q.vd};
            OFF_IOUT:  rd = {16'h0, q.s2.iout};
            OFF_TEMP:  rd = {16'h0, q.s2.temp};
            OFF_DUTY:  rd = {16'h0, q.duty};
            OFF_FREQ:  rd = {16'h0, q.fsw};
            OFF_VMON:  rd = {16'h0, q.s2.vmon};
            OFF_SFLT:  rd = {27'h0, q.sflt};
            OFF_SVIN:  rd = {16'h0, q.snap.vin};
            OFF_SVOUT: rd = {16'h0, q.snap.vsp - q.snap.vsn};
            OFF_SIOUT: rd = {16'h0, q.snap.iout};
            OFF_STEMP: rd = {16'h0, q.snap.temp};
            default:   rd = 32'h00000000;
        endcase
        d.ack = acc;
        if (acc) begin
            d.rdat = rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.addr  <= ADDR_DEF;
            q.setpt <= SETPT_RST;
            q.oclim <= OCLIM_RST;
            q.otlim <= OTLIM_RST;
            q.dly   <= DLY_RST;
            q.rstep <= RSTEP_RST;
            q.fsw   <= FSW_RST;
            q.st    <= OFPC_OFF;
        end else begin
            q <= d;
        end
    end

    ofpc_ramp #(
        .STEPS_LOG (STEP_LOG)
    ) u_ramp (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (q.rstart),
        .abort_i    (~q.drv),
        .from_i     (q.rfrom),
        .to_i       (q.setpt),
        .step_cyc_i (q.rstep),
        .value_o    (r_val),
        .busy_o     (r_busy),
        .done_o     (r_done)
    );

    ////////////////////////////////////////////////////////////////////
    assign wb_ack_o         = q.ack;
    assign wb_dat_o         = q.rdat;
    assign drv_en_o         = q.drv;
    assign target_o         = q.tgt;
    assign duty_o           = q.duty;
    assign power_good_out_o = q.pg;
    assign fault_o          = q.st == OFPC_LATCH;
    // Offsets only spread input current if all parts share one clock
    assign phase_a_o        = q.ilv;
    assign phase_b_o        = q.ilv + HALF_TURN;

endmodule // ofpc_top

// file: dv/ofpc_props.sv
`timescale 1ns/1ps
module ofpc_props
    import ofpc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        en_i,
    input wire ofpc_adc_t   adc_i,
    input wire logic        drv_en_o,
    input wire logic [15:0] duty_o,
    input wire logic        power_good_out_o,
    input wire logic [3:0]  phase_a_o,
    input wire logic [3:0]  phase_b_o,
    input wire logic        fault_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_phase;
        phase_b_o == phase_a_o + 4'h8;
    endproperty
    a_phase: assert property (p_phase) else $error("phase gap");
    property p_flt_off;
        fault_o |-> !drv_en_o && !power_good_out_o;
    endproperty
    a_flt_off: assert property (p_flt_off) else $error("on in fault");
    property p_pg_drv;
        power_good_out_o |-> drv_en_o;
    endproperty
    a_pg_drv: assert property (p_pg_drv) else $error("pg no drv");
    property p_duty;
        !drv_en_o |-> duty_o == 16'h0000;
    endproperty
    a_duty: assert property (p_duty) else $error("duty when off");
    property p_ov;
        drv_en_o && adc_i.vsp >= 16'hF000 |-> ##[1:6] !drv_en_o;
    endproperty
    a_ov: assert property (p_ov) else $error("ov not shut");
    // Clear writes and enable drops take a few cycles to land
    property p_hold;
        fault_o && en_i && $past(en_i, 3) && !wb_cyc_i
            && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |=> fault_o;
    endproperty
    a_hold: assert property (p_hold) else $error("fault lost");
endmodule // ofpc_props

// file: dv/ofpc_plant.sv
`timescale 1ns/1ps
module ofpc_plant
    import ofpc_pkg::*;
(
    input  wire logic        drv_en_i,
    input  wire logic [15:0] target_i,
    input  wire logic [15:0] pre_i,
    input  wire logic        ovr_i,
    input  wire logic [15:0] iout_i,
    input  wire logic [15:0] temp_i,
    output ofpc_adc_t        adc_o
);
    // Ideal stage: output follows target, else the external prebias
    always_comb begin
        adc_o.vin  = 16'h2EE0;
        adc_o.vsp  = ovr_i ? 16'hF000 : (drv_en_i ? target_i : pre_i);
        adc_o.vsn  = 16'h0000;
        adc_o.iout = iout_i;
        adc_o.ipk  = iout_i;
        adc_o.temp = temp_i;
        adc_o.vmon = 16'h0100;
    end
endmodule // ofpc_plant

// file: dv/ofpc_top_tb.sv
`timescale 1ns/1ps
module ofpc_top_tb
    import ofpc_pkg::*;
;
    logic        clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, en_i, ovr;
    logic        wb_ack_o, drv_en_o, power_good_out_o, fault_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i, phase_a_o, phase_b_o;
    logic [15:0] target_o, duty_o, pre, iout, temp;
    ofpc_adc_t   adc;
    int          fail_count, checks, n;
    logic [7:0]  toff[7] = '{OFF_VIN, OFF_VOUT, OFF_IOUT, OFF_TEMP,
                             OFF_DUTY, OFF_FREQ, OFF_VMON};
    logic [15:0] texp[7] = '{16'h2EE0, 16'h03E8, 16'h0000, 16'h0019,
                             16'h1555, 16'h01A5, 16'h0100};

    ofpc_top #(.RETRY_CYCLES(200)) uut (
        .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_stb_i, .wb_cyc_i, .wb_dat_o, .wb_ack_o, .adc_i(adc), .en_i,
        .addr_strap_i(7'h23), .drv_en_o, .target_o, .duty_o,
        .power_good_out_o, .phase_a_o, .phase_b_o, .fault_o);
    ofpc_plant plant (.drv_en_i(drv_en_o), .target_i(target_o),
        .pre_i(pre), .ovr_i(ovr), .iout_i(iout), .temp_i(temp),
        .adc_o(adc));

    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("mismatches %0d of %0d checks", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i  <= w;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            complete_run();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    // Waits on drive (0), power good (1) or fault (2)
    task automatic wt(input int s, input logic v);
        logic x;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            x = s == 0 ? drv_en_o : (s == 1 ? power_good_out_o : fault_o);
        end while (x !== v && n < 3000);
        if (n >= 3000) begin
            fail_count++;
            complete_run();
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, en_i, ovr, iout, pre, temp} = {3'b100, 16'h0, 16'h01F4,
                                               16'h0019};
        {wb_we_i, wb_stb_i, wb_cyc_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(phase_a_o, 4'h3);
        chk(phase_b_o, 4'hB);
        bus(0, OFF_OVLIM, 0); chk(rd, 32'h047E);
        bus(0, OFF_OTLIM, 0); chk(rd, 32'h0073);
        bus(0, OFF_OCLIM, 0); chk(rd, 32'hC350);
        bus(0, 8'hFC, 0); chk(rd, 32'h0);
        bus(0, OFF_STAT, 0); chk(rd[16:10], 7'h23);
        bus(1, OFF_DLY, 10);
        bus(1, OFF_RSTEP, 1);
        en_i <= 1'b1;
        bus(1, OFF_CTRL, 1);
        wt(0, 1); chk(target_o, 16'h01F4);
        wt(1, 1); chk(n >= 254 && n <= 258, 1);
        chk(target_o, 16'h03E8);
        for (int i = 0; i < 7; i++) begin
            bus(0, toff[i], 0); chk(rd, texp[i]);
        end
        iout <= 16'hC351;
        wt(0, 0); iout <= 16'h0; chk(fault_o, 0);
        wt(0, 1); chk(n >= 209 && n <= 220, 1);
        wt(1, 1);
        ovr <= 1'b1;
        wt(0, 0); ovr <= 1'b0;
        repeat (300) @(posedge clk_i);
        chk({fault_o, drv_en_o}, 2'b10);
        // Flags stick until cleared: the earlier average trip still shows
        bus(0, OFF_STAT, 0); chk(rd[9:5], 5'h03);
        bus(0, OFF_SFLT, 0); chk(rd, 32'h00000003);
        bus(1, OFF_CTRL, 3); wt(1, 1); chk(fault_o, 0);
        temp <= 16'h0080;
        wt(0, 0);
        repeat (300) @(posedge clk_i);
        chk(fault_o, 1);
        bus(0, OFF_STAT, 0); chk(rd[9], 1);
        bus(1, OFF_OTLIM, 32'h0096);
        bus(1, OFF_CTRL, 3); wt(1, 1); chk(fault_o, 0);
        bus(1, OFF_CTRL, 0); wt(0, 0);
        pre <= 16'h044C;
        bus(1, OFF_CTRL, 1); wt(0, 1);
        repeat (2) @(posedge clk_i);
        chk(target_o, 16'h044C);
        chk(duty_o, 16'h1777);
        wt(1, 1); chk(n >= 252 && n <= 258, 1);
        repeat (400) @(posedge clk_i);
        chk(target_o, 16'h03E8);
        bus(1, OFF_CTRL, 0); wt(0, 0);
        pre <= 16'h04B0;
        bus(1, OFF_CTRL, 1); wt(2, 1); chk(drv_en_o, 0);
        bus(0, OFF_STAT, 0); chk(rd[8], 1);
        bus(1, OFF_OVLIM, 32'h0500);
        bus(0, OFF_OVLIM, 0); chk(rd, 32'h0500);
        bus(1, OFF_CTRL, 3); wt(0, 1); chk(fault_o, 0);
        bus(1, OFF_ILV, 32'h15);
        repeat (3) @(posedge clk_i);
        chk({phase_a_o, phase_b_o}, 8'h5D);
        bus(0, OFF_ILV, 0); chk(rd[4:0], 5'h15);
        complete_run();
    end
endmodule // ofpc_top_tb

bind ofpc_top ofpc_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .en_i, .adc_i, .drv_en_o, .duty_o, .power_good_out_o,
    .phase_a_o, .phase_b_o, .fault_o);
